// [hdl/rfq_pkg.sv]
// How it works
// - large read pointer holds address bits 17..2; address is base plus pointer times four.
// - large end field holds address bits 17..2; address is base plus field times four.
// - small start field holds address bits 17..2; address is base plus field times four.
// - small write pointer holds address bits 17..2; address is base plus pointer times four.
// - small read pointer holds address bits 17..2; address is base plus pointer times four.
// - low base half waits in a holding register until the high half is written.
// - any asserted byte enable writes all bits; none asserted means no register access, but a read still gets RD_VALID with zero data.
package rfq_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PTR_W = 16;
   localparam int PTR_SHIFT = 2;
   localparam int NPTR = 5;
   localparam int MIN_WR_SPACING = 4;

   localparam logic [ADDR_W-1:0] OFF_BASE_LSW = 12'h290;
   localparam logic [ADDR_W-1:0] OFF_BASE_MSW = 12'h294;
   localparam logic [ADDR_W-1:0] OFF_LQ_READ = 12'h2A0;
   localparam logic [ADDR_W-1:0] OFF_LQ_END = 12'h2A4;
   localparam logic [ADDR_W-1:0] OFF_SQ_START = 12'h2A8;
   localparam logic [ADDR_W-1:0] OFF_SQ_WRITE = 12'h2AC;
   localparam logic [ADDR_W-1:0] OFF_SQ_READ = 12'h2B0;

   localparam int IDX_LQ_READ = 0;
   localparam int IDX_LQ_END = 1;
   localparam int IDX_SQ_START = 2;
   localparam int IDX_SQ_WRITE = 3;
   localparam int IDX_SQ_READ = 4;

   localparam logic [NPTR-1:0][ADDR_W-1:0] PTR_OFF =
      {OFF_SQ_READ, OFF_SQ_WRITE, OFF_SQ_START, OFF_LQ_END, OFF_LQ_READ};

   localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
   localparam logic [PTR_W-1:0] HALF_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] BASE_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
   localparam logic [3:0] BE_NONE_N = 4'hF;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [3:0] be_n;
      logic [DATA_W-1:0] wdata;
   } rfq_req_t;

   typedef struct packed {
      logic sq_read;
      logic sq_write;
      logic lq_read;
   } rfq_adv_t;
endpackage

// [hdl/rfq_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module rfq_regs import rfq_pkg::*; (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire rfq_req_t REQ,
   input wire rfq_adv_t ADV,
   input wire logic [PTR_W-1:0] LQ_START,
   input wire logic [PTR_W-1:0] SQ_END,
   output logic [DATA_W-1:0] RD_DATA,
   output logic RD_VALID,
   output logic [NPTR-1:0][DATA_W-1:0] PHYS_ADDR,
   output logic [NPTR-1:0][PTR_W-1:0] PTR
);
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   logic wr_en;
   logic rd_en;
   logic [DATA_W-1:0] base;
   logic [DATA_W-1:0] next_base;
   logic [PTR_W-1:0] base_hold;
   logic [PTR_W-1:0] next_base_hold;
   logic [DATA_W-1:0] next_rd_data;
   logic next_rd_valid;
   logic [NPTR-1:0] adv;
   logic [NPTR-1:0][PTR_W-1:0] wrap_start;
   logic [NPTR-1:0][PTR_W-1:0] wrap_end;

   // byte lanes are not separately writable
   assign wr_en = REQ.wr && (REQ.be_n != BE_NONE_N);
   assign rd_en = REQ.rd && (REQ.be_n != BE_NONE_N);

   assign adv = {ADV.sq_read, ADV.sq_write, 1'b0, 1'b0, ADV.lq_read};
   assign wrap_start = {PTR[IDX_SQ_START], PTR[IDX_SQ_START], PTR_RESET, PTR_RESET, LQ_START};
   assign wrap_end = {SQ_END, SQ_END, PTR_RESET, PTR_RESET, PTR[IDX_LQ_END]};

   // base only moves on the high-half write so the DMA never sees a torn base
   always_comb begin
      next_base_hold = base_hold;
      next_base = base;
      if (wr_en && hit(REQ.addr, OFF_BASE_LSW)) begin
         next_base_hold = REQ.wdata[PTR_W-1:0];
      end
      if (wr_en && hit(REQ.addr, OFF_BASE_MSW)) begin
         next_base = {REQ.wdata[PTR_W-1:0], base_hold};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         base <= BASE_RESET;
         base_hold <= HALF_RESET;
      end else begin
         base <= next_base;
         base_hold <= next_base_hold;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPTR; g++) begin : g_ptr
         logic [PTR_W-1:0] next_ptr;
         always_comb begin
            next_ptr = PTR[g];
            // host write beats a same-cycle advance
            if (wr_en && hit(REQ.addr, PTR_OFF[g])) begin
               next_ptr = REQ.wdata[PTR_W-1:0];
            end else if (adv[g]) begin
               next_ptr = (PTR[g] == wrap_end[g]) ? wrap_start[g] : PTR[g] + 16'h0001;
            end
         end
         always_ff @(posedge CLK_SYS) begin
            if (!NRST) begin
               PTR[g] <= PTR_RESET;
               PHYS_ADDR[g] <= BASE_RESET;
            end else begin
               PTR[g] <= next_ptr;
               PHYS_ADDR[g] <= next_base + {14'h0000, next_ptr, 2'b00};
            end
         end
      end
   endgenerate

   always_comb begin
      next_rd_data = RDATA_ZERO;
      next_rd_valid = REQ.rd;
      if (rd_en) begin
         if (hit(REQ.addr, OFF_BASE_LSW)) begin
            next_rd_data = {16'h0000, base_hold};
         end else if (hit(REQ.addr, OFF_BASE_MSW)) begin
            next_rd_data = {16'h0000, base[DATA_W-1:PTR_W]};
         end
         for (int i = 0; i < NPTR; i++) begin
            if (hit(REQ.addr, PTR_OFF[i])) begin
               next_rd_data = {16'h0000, PTR[i]};
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         RD_DATA <= RDATA_ZERO;
         RD_VALID <= 1'b0;
      end else begin
         RD_DATA <= next_rd_data;
         RD_VALID <= next_rd_valid;
      end
   end

   // checks
   logic past_valid;
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         past_valid <= 1'b0;
      end else begin
         past_valid <= 1'b1;
      end
   end

   property p_lq_read_addr;
      @(posedge CLK_SYS) disable iff (!NRST)
      past_valid |-> PHYS_ADDR[IDX_LQ_READ] == base + {14'h0000, PTR[IDX_LQ_READ], 2'b00};
   endproperty
   a_lq_read_addr: assert property (p_lq_read_addr) else $error("large read address wrong");

   property p_lq_end_addr;
      @(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_LQ_END)) |=>
         PHYS_ADDR[IDX_LQ_END] == base + {14'h0000, $past(REQ.wdata[15:0]), 2'b00};
   endproperty
   a_lq_end_addr: assert property (p_lq_end_addr) else $error("large end address wrong");

   property p_sq_start_addr;
      @(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_SQ_START)) |=> PTR[IDX_SQ_START] == $past(REQ.wdata[15:0])
         ##0 PHYS_ADDR[IDX_SQ_START] == base + {14'h0000, PTR[IDX_SQ_START], 2'b00};
   endproperty
   a_sq_start_addr: assert property (p_sq_start_addr) else $error("small start wrong");

   property p_sq_write_addr;
      @(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_BASE_MSW)) |=>
         base == {$past(REQ.wdata[15:0]), $past(base_hold)}
         ##0 PHYS_ADDR[IDX_SQ_WRITE] == base + {14'h0000, PTR[IDX_SQ_WRITE], 2'b00};
   endproperty
   a_sq_write_addr: assert property (p_sq_write_addr) else $error("small write address wrong");

   property p_sq_read_addr;
      @(posedge CLK_SYS) disable iff (!NRST)
      past_valid |-> PHYS_ADDR[IDX_SQ_READ][1:0] == base[1:0]
         && PHYS_ADDR[IDX_SQ_READ] == base + {14'h0000, PTR[IDX_SQ_READ], 2'b00};
   endproperty
   a_sq_read_addr: assert property (p_sq_read_addr) else $error("small read address wrong");

   property p_base_hold;
      @(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_BASE_LSW)) |=> $stable(base)
         ##0 base_hold == $past(REQ.wdata[15:0]);
   endproperty
   a_base_hold: assert property (p_base_hold) else $error("base changed on low write");

   property p_no_be_no_access;
      @(posedge CLK_SYS) disable iff (!NRST)
      (REQ.wr && REQ.be_n == BE_NONE_N && ADV == '0) |=>
         $stable(PTR) && $stable(base) && $stable(base_hold);
   endproperty
   a_no_be_no_access: assert property (p_no_be_no_access) else $error("write without lanes");

   property p_wrap;
      @(posedge CLK_SYS) disable iff (!NRST)
      (ADV.lq_read && PTR[IDX_LQ_READ] == PTR[IDX_LQ_END] && !wr_en) |=>
         PTR[IDX_LQ_READ] == $past(LQ_START);
   endproperty
   a_wrap: assert property (p_wrap) else $error("large read did not wrap");

   property p_lq_advance;
      @(posedge CLK_SYS) disable iff (!NRST)
      (ADV.lq_read && PTR[IDX_LQ_READ] != PTR[IDX_LQ_END] && !(wr_en && hit(REQ.addr, OFF_LQ_READ)))
         |=> PTR[IDX_LQ_READ] == $past(PTR[IDX_LQ_READ]) + 16'h0001;
   endproperty
   a_lq_advance: assert property (p_lq_advance) else $error("large read did not step");

   property p_sq_advance;
      @(posedge CLK_SYS) disable iff (!NRST)
      (ADV.sq_write && PTR[IDX_SQ_WRITE] != SQ_END && !(wr_en && hit(REQ.addr, OFF_SQ_WRITE)))
         |=> PTR[IDX_SQ_WRITE] == $past(PTR[IDX_SQ_WRITE]) + 16'h0001;
   endproperty
   a_sq_advance: assert property (p_sq_advance) else $error("small write did not step");

   property p_sq_read_wrap;
      @(posedge CLK_SYS) disable iff (!NRST)
      (ADV.sq_read && PTR[IDX_SQ_READ] == SQ_END && !(wr_en && hit(REQ.addr, OFF_SQ_READ)))
         |=> PTR[IDX_SQ_READ] == $past(PTR[IDX_SQ_START]);
   endproperty
   a_sq_read_wrap: assert property (p_sq_read_wrap) else $error("small read did not wrap");

   property p_host_wins;
      @(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_LQ_READ)) |=>
         PTR[IDX_LQ_READ] == $past(REQ.wdata[PTR_W-1:0]);
   endproperty
   a_host_wins: assert property (p_host_wins) else $error("large read write lost");

   property p_rd_refused;
      @(posedge CLK_SYS) disable iff (!NRST)
      (REQ.rd && REQ.be_n == BE_NONE_N) |=>
         RD_VALID && RD_DATA == RDATA_ZERO;
   endproperty
   a_rd_refused: assert property (p_rd_refused) else $error("laneless read not zero");

   property p_rd_ptr;
      @(posedge CLK_SYS) disable iff (!NRST)
      (rd_en && hit(REQ.addr, OFF_SQ_READ)) |=>
         RD_VALID && RD_DATA == {16'h0000, $past(PTR[IDX_SQ_READ])};
   endproperty
   a_rd_ptr: assert property (p_rd_ptr) else $error("small read pointer read wrong");

   c_partial_be: cover property (@(posedge CLK_SYS) disable iff (!NRST)
      REQ.wr && REQ.be_n == 4'hE && hit(REQ.addr, OFF_SQ_READ));
   c_wrap_small: cover property (@(posedge CLK_SYS) disable iff (!NRST)
      ADV.sq_write && PTR[IDX_SQ_WRITE] == SQ_END);
   c_base_update: cover property (@(posedge CLK_SYS) disable iff (!NRST)
      (wr_en && hit(REQ.addr, OFF_BASE_LSW)) ##[1:8] (wr_en && hit(REQ.addr, OFF_BASE_MSW)));
   c_refused_read: cover property (@(posedge CLK_SYS) disable iff (!NRST)
      REQ.rd && REQ.be_n == BE_NONE_N);
   c_lq_wrap: cover property (@(posedge CLK_SYS) disable iff (!NRST)
      ADV.lq_read && PTR[IDX_LQ_READ] == PTR[IDX_LQ_END]);
endmodule // rfq_regs
`default_nettype wire

// [tb/rfq_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rfq_host import rfq_pkg::*; (
   input wire logic CLK_SYS,
   output var rfq_req_t REQ
);
   initial REQ = '0;
   // one strobe, then idle long enough that any next write is legal
   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] ben,
                      input logic [31:0] d);
      @(posedge CLK_SYS);
      #2 REQ = '{addr: a, wr: w, rd: !w, be_n: ben, wdata: d};
      @(posedge CLK_SYS);
      #2 REQ = '0;
      repeat (3) @(posedge CLK_SYS);
      #2;
   endtask
endmodule // rfq_host
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import rfq_pkg::*; ;
   logic CLK_SYS = 1'b0;
   logic NRST = 1'b0;
   rfq_req_t REQ;
   rfq_adv_t ADV = '0;
   logic [15:0] LQ_START = 16'h0000;
   logic [15:0] SQ_END = 16'h0000;
   logic [31:0] RD_DATA;
   logic RD_VALID;
   logic [4:0][31:0] PHYS_ADDR;
   logic [4:0][15:0] PTR;
   logic [31:0] exp_q[$];
   logic [15:0] v[5];
   logic [31:0] base;
   int bad_count = 0;
   int num_checks = 0;
   always #10 CLK_SYS = ~CLK_SYS;
   rfq_host rfq_host_i (.CLK_SYS(CLK_SYS), .REQ(REQ));
   rfq_regs rfq_regs_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ(REQ), .ADV(ADV),
      .LQ_START(LQ_START), .SQ_END(SQ_END), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
      .PHYS_ADDR(PHYS_ADDR), .PTR(PTR));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      rfq_host_i.acc(1'b0, a, 4'h0, 32'h0);
   endtask
   task automatic pulse(input rfq_adv_t a);
      @(posedge CLK_SYS);
      #2 ADV = a;
      @(posedge CLK_SYS);
      #2 ADV = '0;
   endtask
   // read data stands one cycle, so look once just after each edge
   always @(posedge CLK_SYS) begin
      #1;
      if (RD_VALID === 1'b1) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0);
         else check(RD_DATA, exp_q.pop_front());
      end
   end
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      base = $urandom(28);
      base = $urandom & 32'hFFFFFFFC;
      repeat (3) @(posedge CLK_SYS);
      #2 NRST = 1'b1;
      rfq_host_i.acc(1'b1, OFF_BASE_LSW, 4'h0, {16'h0000, base[15:0]});
      check(PHYS_ADDR[0], 32'h0);
      rfq_host_i.acc(1'b1, OFF_BASE_MSW, 4'h7, {16'h0000, base[31:16]});
      check(PHYS_ADDR[0], base);
      for (int i = 0; i < NPTR; i++) begin
         v[i] = 16'($urandom);
         rfq_host_i.acc(1'b1, PTR_OFF[i], 4'($urandom_range(14, 0)), {16'hFFFF, v[i]});
         check(PHYS_ADDR[i], base + {14'h0, v[i], 2'b00});
         rfq_host_i.acc(1'b1, PTR_OFF[i], BE_NONE_N, {16'h0000, ~v[i]});
         check({16'h0, PTR[i]}, {16'h0, v[i]});
         rd(PTR_OFF[i], {16'h0000, v[i]});
      end
      rd(12'h2FC, RDATA_ZERO);
      rd(OFF_BASE_LSW, {16'h0000, base[15:0]});
      rd(OFF_BASE_MSW, {16'h0000, base[31:16]});
      exp_q.push_back(RDATA_ZERO);
      rfq_host_i.acc(1'b0, OFF_SQ_READ, BE_NONE_N, 32'h0);
      LQ_START = 16'($urandom);
      rfq_host_i.acc(1'b1, OFF_LQ_READ, 4'hE, {16'h0000, v[1]});
      pulse(rfq_adv_t'(3'b001));
      check({16'h0, PTR[0]}, {16'h0, LQ_START});
      pulse(rfq_adv_t'(3'b001));
      check(PHYS_ADDR[0], base + {14'h0, LQ_START + 16'h0001, 2'b00});
      SQ_END = v[4];
      pulse(rfq_adv_t'(3'b110));
      check({16'h0, PTR[4]}, {16'h0, v[2]});
      check({16'h0, PTR[3]}, {16'h0, (v[3] == v[4]) ? v[2] : v[3] + 16'h0001});
      for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge CLK_SYS);
      if (exp_q.size() > 0) bad_count++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
